/* bsc_pkg.sv */
// constants, types and reset values for the bus sizing and chip select block
// What this block does
// - even byte uses low lane and D[7:0]; odd byte uses upper lane, D[15:8]
// - even word with 16-bit memory is one cycle; even long is two word cycles
// - each following cycle of a transfer increments A[23:1], except the A0-high byte of a split word
// - odd byte read with 8-bit memory takes data from D[7:0]
// - odd byte write drives both lanes and ignores the size answer
// - even word to 8-bit memory takes low byte, then lower-lane byte with A0 high
// - odd multi-byte transfer starts with upper-lane byte, ends lower-lane byte
// - opcode fetch marker is low in every instruction fetch cycle
// - no periodic dummy I/O cycles imitating fetches are generated
// - I/O clock is divided bus clock; I/O strobes are driven out
// - two I/O selects match programmed base over 8 to 1024 byte windows
// - I/O selects work in memory and I/O cycles, never in acknowledge cycles
// - ROM and RAM selects cover 4KB to 16MB ranges in memory and I/O cycles
// - ROM and RAM waits programmed apart, applied in memory cycles only
// - size line optionally pulled low open-drain inside ROM or RAM range
// - forced byte RAM: low RAM select whole cycle, high pin becomes port bit
// - word RAM: low select gated by lower lane, high select by upper lane
// - high RAM select pin is port bit seven when mode bit 6 is one
// - I/O select pins carry selects when enabled, else port bit or timer
// - overlapping ranges assert only ROM select, RAM selects stay inactive
// - after reset ROM covers A[23:15]=0, RAM the rest, both forced byte wide
package bsc_pkg;

    // transfer sizes requested by software
    localparam logic [1:0] SIZE_8       = 2'h0;
    localparam logic [1:0] SIZE_16      = 2'h1;
    localparam logic [1:0] SIZE_32      = 2'h2;

    // cycles between address phase and data sample, covers the input synchroniser
    localparam int         SETTLE_CYCLES = 2;

    // reset map: ROM over A[23:15] equal to zero, RAM everywhere else
    localparam logic [11:0] ROM_BASE_RST = 12'h000;
    localparam logic [11:0] ROM_MASK_RST = 12'hff8;
    localparam logic [11:0] RAM_BASE_RST = 12'h000;
    localparam logic [11:0] RAM_MASK_RST = 12'h000;
    localparam logic        FORCE8_RST   = 1'h1;
    localparam logic [3:0]  WAITS_RST    = 4'h3;
    localparam logic [3:0]  IO_DIV_RST   = 4'h1;
    localparam logic [12:0] IO_BASE_RST  = 13'h0000;
    localparam logic [2:0]  IO_WIN_RST   = 3'h0;

    typedef enum logic [1:0] {
        KIND_MEM    = 2'h0,
        KIND_IO     = 2'h1,
        KIND_INTERRUPT_ACKNOWLEDGE_CYCLE = 2'h2
    } bsc_kind_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_ADDR   = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_WAITS  = 5'b01000,
        ST_SAMPLE = 5'b10000
    } bsc_state_t;

    // configuration image, loaded as a whole
    typedef struct packed {
        logic [11:0] rom_base;     // A[23:12]
        logic [11:0] rom_mask;     // ones mark compared bits
        logic [11:0] ram_base;
        logic [11:0] ram_mask;
        logic        rom_force8;
        logic        ram_force8;
        logic [3:0]  rom_waits;
        logic [3:0]  ram_waits;
        logic [3:0]  io_waits;
        logic [3:0]  io_clk_div;
        logic        port_c_mode;  // mode bit 6
        logic        io1_en;
        logic [12:0] io1_base;     // A[15:3]
        logic [2:0]  io1_win;      // window is 8 << win bytes
        logic        io2_en;
        logic [12:0] io2_base;
        logic [2:0]  io2_win;
    } bsc_cfg_t;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [23:0] addr;
        logic [31:0] wdata;
        bsc_kind_t   kind;
        logic        fetch;
    } bsc_req_t;

endpackage

/* bsc_bus_sizer.sv */
// bus sizing sequencer, chip select decode and I/O strobe generation
`timescale 1ns/1ps
`default_nettype none

module bsc_bus_sizer
    import bsc_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire logic      cfg_load,
    input  wire bsc_cfg_t  cfg_in,
    input  wire logic      req_valid,
    input  wire bsc_req_t  req,
    output logic           req_ready,
    output logic           resp_done,
    output logic [31:0]    resp_rdata,
    output logic [23:0]    address,
    output logic [15:0]    data_out,
    output logic           data_oe,
    input  wire logic [15:0] data_in,
    output logic           mem_cycle_n,
    output logic           mem_write_n,
    output logic           upper_lane_enable_n,
    output logic           lower_lane_enable_n,
    input  wire logic      mem_size_8bit_n,
    output logic           mem_size_8bit_oe,
    output logic           opcode_fetch_cycle_n,
    output logic           io_request_n,
    output logic           io_read_strobe_n,
    output logic           io_write_strobe_n,
    output logic           io_bus_clock,
    output logic           rom_select_n,
    output logic           ram_select_low_n,
    output logic           ram_high_pin,
    output logic           io_one_pin,
    output logic           io_two_pin,
    input  wire logic      port_c_bit_seven,
    input  wire logic      port_c_bit_six,
    input  wire logic      timer_one_pulse_out
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // byte count of a requested size
    function automatic logic [2:0] size_bytes(input logic [1:0] sz);
        logic [2:0] n;
        n = 3'h1;
        if (sz == SIZE_16) begin
            n = 3'h2;
        end else if (sz == SIZE_32) begin
            n = 3'h4;
        end
        return n;
    endfunction

    // memory range match on A[23:12], 4KB granularity
    function automatic logic mem_hit(input logic [23:0] a, input logic [11:0] base,
                                     input logic [11:0] mask);
        return (((a[23:12] ^ base) & mask) == 12'h000);
    endfunction

    // I/O window match on A[15:3+win]
    function automatic logic io_hit(input logic [23:0] a, input logic [12:0] base,
                                    input logic [2:0] win);
        logic [12:0] m;
        m = 13'h1fff << win;
        return (((a[15:3] ^ base) & m) == 13'h0000);
    endfunction

    // pick byte k of a 32-bit word
    function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] k);
        return w[{k, 3'h0} +: 8];
    endfunction

    // ************************************************************
    // configuration image
    // ************************************************************

    bsc_cfg_t cfg;
    bsc_cfg_t next_cfg;

    // whole image replaced on load, held otherwise
    always_comb begin
        next_cfg = cfg;
        if (cfg_load) begin
            next_cfg = cfg_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.rom_base    <= ROM_BASE_RST;
            cfg.rom_mask    <= ROM_MASK_RST;
            cfg.ram_base    <= RAM_BASE_RST;
            cfg.ram_mask    <= RAM_MASK_RST;
            cfg.rom_force8  <= FORCE8_RST;
            cfg.ram_force8  <= FORCE8_RST;
            cfg.rom_waits   <= WAITS_RST;
            cfg.ram_waits   <= WAITS_RST;
            cfg.io_waits    <= WAITS_RST;
            cfg.io_clk_div  <= IO_DIV_RST;
            cfg.port_c_mode <= 1'h0;
            cfg.io1_en      <= 1'h0;
            cfg.io1_base    <= IO_BASE_RST;
            cfg.io1_win     <= IO_WIN_RST;
            cfg.io2_en      <= 1'h0;
            cfg.io2_base    <= IO_BASE_RST;
            cfg.io2_win     <= IO_WIN_RST;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ************************************************************
    // pin input synchronisers
    // ************************************************************

    logic [16:0] sync_a;
    logic [16:0] sync_b;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 17'h1ffff;
            sync_b <= 17'h1ffff;
        end else begin
            sync_a <= {mem_size_8bit_n, data_in};
            sync_b <= sync_a;
        end
    end

    logic        size8_seen;
    logic [15:0] data_seen;
    assign size8_seen = ~sync_b[16];
    assign data_seen  = sync_b[15:0];

    // ************************************************************
    // sequencer
    // ************************************************************

    bsc_state_t  state;
    bsc_state_t  next_state;
    bsc_req_t    cur;
    bsc_req_t    next_cur;
    logic [23:0] addr;
    logic [23:0] next_addr;
    logic [2:0]  remain;
    logic [2:0]  next_remain;
    logic [1:0]  bidx;
    logic [1:0]  next_bidx;
    logic        split;
    logic        next_split;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        done;
    logic        next_done;

    // shape of the current bus cycle
    logic        odd_byte;
    logic        word_cyc;
    logic [23:0] cyc_addr;
    logic        upper_on;
    logic        lower_on;
    logic        rom_hit;
    logic        ram_hit;
    logic [3:0]  wait_sel;
    logic [7:0]  wb0;
    logic [7:0]  wb1;

    always_comb begin
        odd_byte = addr[0] & ~split;
        word_cyc = ~addr[0] & ~split & (remain >= 3'h2);
        cyc_addr = {addr[23:1], addr[0] | split};
        upper_on = word_cyc | odd_byte;
        lower_on = ~odd_byte;
        rom_hit  = mem_hit(cyc_addr, cfg.rom_base, cfg.rom_mask);
        ram_hit  = mem_hit(cyc_addr, cfg.ram_base, cfg.ram_mask) & ~rom_hit;
        wb0      = pick_byte(cur.wdata, bidx);
        wb1      = pick_byte(cur.wdata, bidx + 2'h1);
        // waits per range for memory, one setting for all I/O traffic
        wait_sel = 4'h0;
        if (cur.kind == KIND_MEM) begin
            if (rom_hit) begin
                wait_sel = cfg.rom_waits;
            end else if (ram_hit) begin
                wait_sel = cfg.ram_waits;
            end
        end else begin
            wait_sel = cfg.io_waits;
        end
    end

    // cycles are only ever started by a request, no idle filler traffic
    always_comb begin
        next_state  = state;
        next_cur    = cur;
        next_addr   = addr;
        next_remain = remain;
        next_bidx   = bidx;
        next_split  = split;
        next_cnt    = cnt;
        next_rdata  = rdata;
        next_done   = 1'h0;
        case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    next_cur    = req;
                    next_addr   = req.addr;
                    next_remain = size_bytes(req.size);
                    next_bidx   = 2'h0;
                    next_split  = 1'h0;
                    next_rdata  = 32'h0000_0000;
                    next_state  = ST_ADDR;
                end
            end
            ST_ADDR: begin
                next_cnt   = 4'(SETTLE_CYCLES - 1);
                next_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (cnt == 4'h0) begin
                    next_cnt   = wait_sel;
                    next_state = (wait_sel == 4'h0) ? ST_SAMPLE : ST_WAITS;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_WAITS: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (word_cyc && !size8_seen) begin
                    // full word taken, step to next word address
                    next_rdata[{bidx, 3'h0} +: 16] = data_seen;
                    next_addr   = addr + 24'h2;
                    next_bidx   = bidx + 2'h2;
                    next_remain = remain - 3'h2;
                end else if (word_cyc) begin
                    // byte-wide memory answered, low byte only, same word again
                    next_rdata[{bidx, 3'h0} +: 8] = data_seen[7:0];
                    next_split  = 1'h1;
                    next_bidx   = bidx + 2'h1;
                    next_remain = remain - 3'h1;
                end else if (odd_byte) begin
                    // write side ignores the size answer altogether
                    next_rdata[{bidx, 3'h0} +: 8] = size8_seen ? data_seen[7:0]
                                                               : data_seen[15:8];
                    next_addr   = addr + 24'h1;
                    next_bidx   = bidx + 2'h1;
                    next_remain = remain - 3'h1;
                end else begin
                    // lower-lane byte: even byte or second half of a split word
                    next_rdata[{bidx, 3'h0} +: 8] = data_seen[7:0];
                    next_addr   = {addr[23:1], 1'h0} + 24'h2;
                    next_split  = 1'h0;
                    next_bidx   = bidx + 2'h1;
                    next_remain = remain - 3'h1;
                end
                if (next_remain == 3'h0) begin
                    next_done  = 1'h1;
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_ADDR;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state  <= ST_IDLE;
            cur    <= '0;
            addr   <= 24'h00_0000;
            remain <= 3'h0;
            bidx   <= 2'h0;
            split  <= 1'h0;
            cnt    <= 4'h0;
            rdata  <= 32'h0000_0000;
            done   <= 1'h0;
        end else begin
            state  <= next_state;
            cur    <= next_cur;
            addr   <= next_addr;
            remain <= next_remain;
            bidx   <= next_bidx;
            split  <= next_split;
            cnt    <= next_cnt;
            rdata  <= next_rdata;
            done   <= next_done;
        end
    end

    // ************************************************************
    // registered pin values
    // ************************************************************

    logic        in_cyc;
    logic        strobe_on;
    logic        sel_ok;
    logic        ram_low_c;
    logic        ram_high_c;
    logic        io1_c;
    logic        io2_c;
    logic [15:0] wdata_c;
    logic [3:0]  div_cnt;
    logic [3:0]  next_div_cnt;
    logic        next_io_clk;

    // strobes wait one clock after the address so it is stable first
    always_comb begin
        in_cyc     = (state != ST_IDLE);
        strobe_on  = in_cyc && (state != ST_ADDR);
        sel_ok     = in_cyc && (cur.kind != KIND_INTERRUPT_ACKNOWLEDGE_CYCLE);
        // forced byte RAM keeps the low select for the whole cycle
        ram_low_c  = sel_ok && ram_hit && (cfg.ram_force8 || lower_on);
        ram_high_c = sel_ok && ram_hit && !cfg.ram_force8 && upper_on;
        io1_c      = sel_ok && cfg.io1_en && io_hit(cyc_addr, cfg.io1_base, cfg.io1_win);
        io2_c      = sel_ok && cfg.io2_en && io_hit(cyc_addr, cfg.io2_base, cfg.io2_win);
        // odd byte goes on both lanes so either memory width catches it
        wdata_c    = word_cyc ? {wb1, wb0} : {wb0, wb0};
        // free-running divider, period is 2*(div+1) bus clocks
        next_div_cnt = div_cnt + 4'h1;
        next_io_clk  = io_bus_clock;
        if (div_cnt >= cfg.io_clk_div) begin
            next_div_cnt = 4'h0;
            next_io_clk  = ~io_bus_clock;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_ready            <= 1'h0;
            resp_done            <= 1'h0;
            resp_rdata           <= 32'h0000_0000;
            address              <= 24'h00_0000;
            data_out             <= 16'h0000;
            data_oe              <= 1'h0;
            mem_cycle_n          <= 1'h1;
            mem_write_n          <= 1'h1;
            upper_lane_enable_n  <= 1'h1;
            lower_lane_enable_n  <= 1'h1;
            mem_size_8bit_oe     <= 1'h0;
            opcode_fetch_cycle_n <= 1'h1;
            io_request_n         <= 1'h1;
            io_read_strobe_n     <= 1'h1;
            io_write_strobe_n    <= 1'h1;
            io_bus_clock         <= 1'h0;
            div_cnt              <= 4'h0;
            rom_select_n         <= 1'h1;
            ram_select_low_n     <= 1'h1;
            ram_high_pin         <= 1'h1;
            io_one_pin           <= 1'h1;
            io_two_pin           <= 1'h1;
        end else begin
            req_ready            <= (next_state == ST_IDLE);
            resp_done            <= done;
            resp_rdata           <= done ? rdata : resp_rdata;
            address              <= in_cyc ? cyc_addr : address;
            data_out             <= wdata_c;
            data_oe              <= in_cyc && cur.write;
            mem_cycle_n          <= ~(strobe_on && cur.kind == KIND_MEM);
            mem_write_n          <= ~(strobe_on && cur.kind == KIND_MEM && cur.write);
            upper_lane_enable_n  <= ~(in_cyc && upper_on);
            lower_lane_enable_n  <= ~(in_cyc && lower_on);
            // open-drain pull on the size line inside a forced range
            mem_size_8bit_oe     <= sel_ok && ((rom_hit && cfg.rom_force8) ||
                                               (ram_hit && cfg.ram_force8));
            opcode_fetch_cycle_n <= ~(strobe_on && cur.kind == KIND_MEM && cur.fetch);
            io_request_n         <= ~(strobe_on && cur.kind != KIND_MEM);
            io_read_strobe_n     <= ~(strobe_on && cur.kind == KIND_IO && !cur.write);
            io_write_strobe_n    <= ~(strobe_on && cur.kind == KIND_IO && cur.write);
            io_bus_clock         <= next_io_clk;
            div_cnt              <= next_div_cnt;
            rom_select_n         <= ~(sel_ok && rom_hit);
            ram_select_low_n     <= ~ram_low_c;
            // shared pins follow their mode every clock
            ram_high_pin         <= (cfg.port_c_mode || cfg.ram_force8) ? port_c_bit_seven
                                                                        : ~ram_high_c;
            io_one_pin           <= cfg.io1_en ? ~io1_c : port_c_bit_six;
            io_two_pin           <= cfg.io2_en ? ~io2_c : timer_one_pulse_out;
        end
    end

endmodule

`default_nettype wire

/* bsc_sizer_assertions.sv */
// port-level checks for the bus sizing and chip select block
`timescale 1ns/1ps
`default_nettype none
module bsc_sizer_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        resp_done,
    input wire logic [23:0] address,
    input wire logic [15:0] data_out,
    input wire logic        mem_cycle_n,
    input wire logic        mem_write_n,
    input wire logic        upper_lane_enable_n,
    input wire logic        lower_lane_enable_n,
    input wire logic        mem_size_8bit_oe,
    input wire logic        opcode_fetch_cycle_n,
    input wire logic        io_request_n,
    input wire logic        io_read_strobe_n,
    input wire logic        rom_select_n,
    input wire logic        ram_select_low_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a request counts only when both handshake sides are high
    sequence s_take; req_valid && req_ready; endsequence
    property p_even; !mem_cycle_n && !address[0] |-> !lower_lane_enable_n; endproperty
    a_even: assert property (p_even) else $error("even cycle lacks low lane");
    property p_odd; !mem_cycle_n && address[0] |-> upper_lane_enable_n != lower_lane_enable_n; endproperty
    a_odd: assert property (p_odd) else $error("odd cycle lane pair wrong");
    property p_dup; !mem_write_n && address[0] && !upper_lane_enable_n |-> data_out[15:8] == data_out[7:0]; endproperty
    a_dup: assert property (p_dup) else $error("odd write byte not on both lanes");
    property p_fetch; !opcode_fetch_cycle_n |-> !mem_cycle_n && io_request_n; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch marker outside memory cycle");
    property p_io; !io_read_strobe_n |-> !io_request_n && mem_cycle_n; endproperty
    a_io: assert property (p_io) else $error("read strobe without request");
    property p_pull; mem_size_8bit_oe && !mem_cycle_n |-> !(rom_select_n && ram_select_low_n); endproperty
    a_pull: assert property (p_pull) else $error("size pulled outside ranges");
    property p_rom; !rom_select_n |-> ram_select_low_n; endproperty
    a_rom: assert property (p_rom) else $error("both ROM and RAM selected");
    // the shortest bus cycle keeps ready low for at least three clocks
    property p_busy; s_take |=> !req_ready [*3]; endproperty
    a_busy: assert property (p_busy) else $error("ready back too early");
    property p_done; s_take |-> ##[3:600] resp_done; endproperty
    a_done: assert property (p_done) else $error("transfer never finished");
endmodule
bind bsc_bus_sizer bsc_sizer_chk chk_u (.*);
`default_nettype wire

/* bsc_mem_model.sv */
// far-side memory model, byte or word wide, 32 bytes deep
`timescale 1ns/1ps
`default_nettype none
module bsc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        narrow,
    input  wire logic [23:0] address,
    input  wire logic [15:0] data_out,
    input  wire logic        mem_write_n,
    input  wire logic        upper_lane_enable_n,
    input  wire logic        lower_lane_enable_n,
    output logic [15:0]      data_in,
    output logic             size_n
);
    logic [7:0]  mem [32];
    logic [15:0] junk = 16'h5a5a;
    logic        act;
    logic [4:0]  a;
    initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 7 + 3);
    assign a = address[4:0];
    assign act = !(upper_lane_enable_n && lower_lane_enable_n);
    // byte memory pulls the size line in each of its cycles
    assign size_n = !(narrow && act);
    // undriven lanes show a changing pattern, never the last value
    assign data_in = !act ? junk : narrow ? {junk[15:8], mem[a]} : {mem[a | 5'h1], mem[a & 5'h1e]};
    always @(posedge ref_clk) begin
        junk <= ~junk;
        if (!mem_write_n && narrow) mem[a] <= data_out[7:0];
        if (!mem_write_n && !narrow && !lower_lane_enable_n) mem[a & 5'h1e] <= data_out[7:0];
        if (!mem_write_n && !narrow && !upper_lane_enable_n) mem[a | 5'h1] <= data_out[15:8];
    end
endmodule
`default_nettype wire

/* bsc_testbench.sv */
// self-checking bench: sized transfers, selects and I/O strobes
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bsc_pkg::*;
    logic        ref_clk = 0, rst = 1, cfg_load = 0, req_valid = 0, narrow = 1, mc_q = 1;
    logic        port_c_bit_seven = 0, port_c_bit_six = 1, timer_one_pulse_out = 0;
    bsc_cfg_t    cfg_in = '0;
    bsc_req_t    req = '0;
    logic [31:0] resp_rdata;
    logic [23:0] address;
    logic [15:0] data_out, data_in;
    logic        req_ready, resp_done, data_oe, mem_cycle_n, mem_write_n, mem_size_8bit_oe;
    logic        upper_lane_enable_n, lower_lane_enable_n, opcode_fetch_cycle_n, io_bus_clock;
    logic        io_request_n, io_read_strobe_n, io_write_strobe_n, rom_select_n, ext_n;
    logic        ram_select_low_n, ram_high_pin, io_one_pin, io_two_pin;
    logic [7:0]  shadow [32];
    int          failures = 0, n_compared = 0, n_cyc, n_io1, n_rd, n_fetch, n_tog;
    logic        ck_q = 0;
    wire logic   mem_size_8bit_n = ~mem_size_8bit_oe & ext_n;
    bsc_bus_sizer dut_u (.*);
    bsc_mem_model mem_u (.ref_clk, .narrow, .address, .data_out, .mem_write_n,
        .upper_lane_enable_n, .lower_lane_enable_n, .data_in, .size_n(ext_n));
    always #2.5 ref_clk = ~ref_clk;
    // pin activity counted mid-cycle, away from the driving edge
    always @(negedge ref_clk) begin
        mc_q <= mem_cycle_n;
        n_cyc += (mc_q && !mem_cycle_n);
        n_io1 += !io_one_pin;
        n_rd += !io_read_strobe_n;
        n_fetch += !opcode_fetch_cycle_n;
        ck_q <= io_bus_clock;
        n_tog += (ck_q != io_bus_clock);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one transfer; bytes outside the size are masked off
    task automatic xfer(input logic wr, input logic [1:0] sz, input logic [23:0] a,
                        input bsc_kind_t k, input logic f, input int ncyc);
        int          i;
        logic [31:0] m, wd, e;
        i = 0;
        m = {{16{sz[1]}}, {8{sz != 2'h0}}, 8'hff};
        wd = 32'h44332211 ^ {4{a[7:0]}};
        e = '0;
        for (int j = 0; j < 4; j++) begin
            if (wr && m[8*j]) shadow[5'(a[4:0] + j)] = wd[8*j +: 8];
            e[8*j +: 8] = shadow[5'(a[4:0] + j)] & m[8*j +: 8];
        end
        do begin
            @(posedge ref_clk);
            #1;
            i++;
        end while (req_ready !== 1'b1 && i < 50);
        if (i >= 50) failures++;
        @(posedge ref_clk);
        req <= '{wr, sz, a, wd, k, f};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        {n_cyc, n_io1, n_rd, n_fetch} = '0;
        while (resp_done !== 1'b1 && i < 650) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        if (i >= 650) failures++;
        if (i >= 650) test_done();
        if (ncyc >= 0) chk(n_cyc, ncyc);
        if (!wr && k == KIND_MEM) chk(resp_rdata & m, e);
        $display("test at %h size %0d done", a, sz);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        for (int j = 0; j < 32; j++) shadow[j] = 8'(j * 7 + 3);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'h0, SIZE_32, 24'h5, KIND_MEM, 1'h0, 4);
        xfer(1'h0, SIZE_16, 24'h8012, KIND_MEM, 1'h0, 2);
        // reset map: shared pins carry their port and timer functions
        chk({ram_high_pin, io_one_pin, io_two_pin}, 3'b010);
        // word-wide map, io select one on an 8-byte window at 20h
        cfg_in <= '{12'h0, 12'hff8, 12'h0, 12'h0, 1'h0, 1'h0, 4'h1, 4'h2, 4'h1, 4'h1,
                    1'h0, 1'h1, 13'h4, 3'h0, 1'h0, 13'h0, 3'h0};
        cfg_load <= 1'b1;
        narrow <= 1'b0;
        @(posedge ref_clk);
        cfg_load <= 1'b0;
        xfer(1'h0, SIZE_8, 24'h3, KIND_MEM, 1'h0, 1);
        xfer(1'h0, SIZE_8, 24'h2, KIND_MEM, 1'h0, 1);
        xfer(1'h0, SIZE_32, 24'h8, KIND_MEM, 1'h0, 2);
        xfer(1'h0, SIZE_32, 24'h1, KIND_MEM, 1'h0, 3);
        xfer(1'h1, SIZE_32, 24'h9, KIND_MEM, 1'h0, 3);
        xfer(1'h1, SIZE_8, 24'hf, KIND_MEM, 1'h0, 1);
        xfer(1'h0, SIZE_32, 24'h9, KIND_MEM, 1'h0, 3);
        xfer(1'h0, SIZE_16, 24'he, KIND_MEM, 1'h1, 1);
        chk(n_fetch > 0, 1);
        narrow <= 1'b1;
        xfer(1'h0, SIZE_16, 24'h8010, KIND_MEM, 1'h0, 2);
        xfer(1'h0, SIZE_8, 24'h8013, KIND_MEM, 1'h0, 1);
        xfer(1'h1, SIZE_16, 24'h8014, KIND_MEM, 1'h0, 2);
        xfer(1'h0, SIZE_32, 24'h8013, KIND_MEM, 1'h0, 4);
        xfer(1'h0, SIZE_8, 24'h20, KIND_IO, 1'h0, 0);
        chk(n_io1 > 0 && n_rd > 0, 1);
        xfer(1'h0, SIZE_8, 24'h20, KIND_INTERRUPT_ACKNOWLEDGE_CYCLE, 1'h0, 0);
        chk(n_io1 + n_rd, 0);
        xfer(1'h0, SIZE_8, 24'h28, KIND_IO, 1'h0, 0);
        chk(n_io1, 0);
        // divider of one: the I/O clock flips every second bus clock
        n_tog = 0;
        repeat (40) @(posedge ref_clk);
        chk(n_tog, 20);
        test_done();
    end
endmodule
`default_nettype wire
